// >>> pkg/slpg_regs.vh
/*
  timing constants and pattern phase lengths for the status led pattern generator.
  assumes a 100 MHz core clock and a 1 ms tick derived from it.
*/
`ifndef SLPG_REGS_VH
`define SLPG_REGS_VH

`define SLPG_CLK_HZ          100000000
`define SLPG_TICK_HZ         1000
`define SLPG_TICK_CYCLES     (`SLPG_CLK_HZ / `SLPG_TICK_HZ)
`define SLPG_FLICKER_MS      50
`define SLPG_BLINK_MS        200
`define SLPG_DBL_PAUSE_MS    1000
`define SLPG_DIST_LATENCY_MS 15
`define SLPG_SAMPLE_BITS     16

`endif

// >>> core/slpg_tick.v
/*
  millisecond tick divider: one-cycle enable pulse every period cycles.
  assumes a single clock and an asynchronous active-low clear from the parent.
*/
`timescale 1ns/100ps
`default_nettype none

module slpg_tick #(
  parameter PERIOD = 100000
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  output reg         tick_o
);

  reg [31:0] count;

  // free-running divider, wraps at period - 1
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count  <= 32'h0000_0000;
      tick_o <= 1'b0;
    end
    else if (count == PERIOD - 1)
    begin
      count  <= 32'h0000_0000;
      tick_o <= 1'b1;
    end
    else
    begin
      count  <= count + 32'h0000_0001;
      tick_o <= 1'b0;
    end
  end

endmodule // slpg_tick

`default_nettype wire

// >>> core/slpg_top.v
/*
  status led pattern generator: maps module state to run and fault led patterns.
  assumes all state inputs come from other clock domains or pins and are synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none
`include "slpg_regs.vh"

module slpg_top #(
  parameter TICK_CYCLES = `SLPG_TICK_CYCLES,
  parameter NCHAN       = 4
) (
  input  wire                                  core_clk_i,
  input  wire                                  rst_n_i,
  input  wire                                  failed_i,
  input  wire                                  watchdog_expired_i,
  input  wire                                  self_test_ok_i,
  input  wire                                  operational_i,
  input  wire                                  auto_addressing_i,
  input  wire                                  pre_operational_i,
  input  wire                                  over_voltage_i,
  input  wire                                  field_power_local_fault_i,
  input  wire                                  field_power_distributor_fault_i,
  input  wire                                  nonfatal_error_i,
  input  wire                                  island_bus_stopped_i,
  input  wire [NCHAN*`SLPG_SAMPLE_BITS-1:0]    chan_sample_i,
  output reg  [NCHAN*`SLPG_SAMPLE_BITS-1:0]    chan_sample_o,
  output reg                                   run_led_o,
  output reg                                   fault_led_o
);

  localparam NIN = 11;
  // full-width copies, then cut on purpose to the counter widths
  localparam [31:0] FLK_MS_W      = `SLPG_FLICKER_MS;
  localparam [31:0] BLK_MS_W      = `SLPG_BLINK_MS;
  localparam [31:0] DBL_MS_W      = 3 * `SLPG_BLINK_MS + `SLPG_DBL_PAUSE_MS;
  localparam [9:0]  FLK_MS        = FLK_MS_W[9:0];
  localparam [9:0]  BLK_MS        = BLK_MS_W[9:0];
  localparam [10:0] DBL_PERIOD_MS = DBL_MS_W[10:0];

  // led pattern selectors, one-hot
  localparam [4:0] PAT_OFF = 5'b00001;
  localparam [4:0] PAT_ON  = 5'b00010;
  localparam [4:0] PAT_FLK = 5'b00100;
  localparam [4:0] PAT_BLK = 5'b01000;
  localparam [4:0] PAT_DBL = 5'b10000;

  reg          rst_s1;
  reg          rst_s2;
  reg [NIN-1:0] in_s1;
  reg [NIN-1:0] in_s;
  wire         tick;
  reg  [9:0]   flk_ms;
  reg          flk_on;
  reg  [9:0]   blk_ms;
  reg          blk_on;
  reg  [10:0]  dbl_ms;
  reg          dbl_on;
  reg  [4:0]   run_pat;
  reg  [4:0]   fault_pat;
  reg          next_run;
  reg          next_fault;

  // reset release through two flops
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // two-flop synchronisers for all state inputs
  always @(posedge core_clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      in_s1 <= {NIN{1'b0}};
      in_s  <= {NIN{1'b0}};
    end
    else
    begin
      in_s1 <= {failed_i, watchdog_expired_i, self_test_ok_i, operational_i,
                auto_addressing_i, pre_operational_i, over_voltage_i,
                field_power_local_fault_i, field_power_distributor_fault_i,
                nonfatal_error_i, island_bus_stopped_i};
      in_s  <= in_s1;
    end
  end

  wire s_failed = in_s[10];
  wire s_wdog   = in_s[9];
  wire s_test   = in_s[8];
  wire s_oper   = in_s[7];
  wire s_addr   = in_s[6];
  wire s_preop  = in_s[5];
  wire s_ovv    = in_s[4];
  wire s_fplocal = in_s[3];
  // distributor faults arrive already up to 15 ms late; no filtering added on top
  wire s_fpdist = in_s[2];
  wire s_nferr  = in_s[1];
  wire s_busoff = in_s[0];

  slpg_tick #(
    .PERIOD (TICK_CYCLES)
  ) u_tick (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_s2),
    .tick_o  (tick)
  );

  // flicker: toggle every 50 ms
  always @(posedge core_clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      flk_ms <= 10'h000;
      flk_on <= 1'b1;
    end
    else if (tick)
    begin
      if (flk_ms == FLK_MS - 10'h001)
      begin
        flk_ms <= 10'h000;
        flk_on <= ~flk_on;
      end
      else
      begin
        flk_ms <= flk_ms + 10'h001;
      end
    end
  end

  // single blink: toggle every 200 ms
  always @(posedge core_clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      blk_ms <= 10'h000;
      blk_on <= 1'b1;
    end
    else if (tick)
    begin
      if (blk_ms == BLK_MS - 10'h001)
      begin
        blk_ms <= 10'h000;
        blk_on <= ~blk_on;
      end
      else
      begin
        blk_ms <= blk_ms + 10'h001;
      end
    end
  end

  // double blink: on, off, on, then a long pause so it reads apart from blink 1
  always @(posedge core_clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      dbl_ms <= 11'h000;
    end
    else if (tick)
    begin
      if (dbl_ms == DBL_PERIOD_MS - 11'h001)
        dbl_ms <= 11'h000;
      else
        dbl_ms <= dbl_ms + 11'h001;
    end
  end

  always @*
  begin
    dbl_on = (dbl_ms < {1'b0, BLK_MS}) ||
             ((dbl_ms >= {1'b0, BLK_MS} + {1'b0, BLK_MS}) &&
              (dbl_ms < {1'b0, BLK_MS} + {1'b0, BLK_MS} + {1'b0, BLK_MS}));
  end

  // pattern selection, highest priority first
  always @*
  begin
    run_pat   = PAT_OFF;
    fault_pat = PAT_OFF;
    if (s_failed)
    begin
      run_pat   = PAT_OFF;
      fault_pat = PAT_OFF;
    end
    else if (s_wdog)
    begin
      run_pat   = PAT_ON;
      fault_pat = PAT_ON;
    end
    else if (s_addr)
    begin
      run_pat   = PAT_FLK;
      fault_pat = PAT_OFF;
    end
    else
    begin
      // run led: pre-operational blink, else steady when healthy or on over-voltage
      if (s_preop)
        run_pat = PAT_BLK;
      else if (s_oper && s_test)
        run_pat = PAT_ON;
      else if (s_ovv)
        run_pat = PAT_ON;
      // fault led: power faults over over-voltage over warnings
      if (s_fplocal || s_fpdist)
        fault_pat = PAT_FLK;
      else if (s_ovv)
        fault_pat = PAT_FLK;
      else if (s_busoff)
        fault_pat = PAT_DBL;
      else if (s_nferr)
        fault_pat = PAT_BLK;
    end
  end

  // pattern to level
  always @*
  begin
    case (run_pat)
      PAT_ON:  next_run = 1'b1;
      PAT_FLK: next_run = flk_on;
      PAT_BLK: next_run = blk_on;
      PAT_DBL: next_run = dbl_on;
      default: next_run = 1'b0;
    endcase
    case (fault_pat)
      PAT_ON:  next_fault = 1'b1;
      PAT_FLK: next_fault = flk_on;
      PAT_BLK: next_fault = blk_on;
      PAT_DBL: next_fault = dbl_on;
      default: next_fault = 1'b0;
    endcase
  end

  // registered outputs; samples pass straight through one flop stage
  always @(posedge core_clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      run_led_o     <= 1'b0;
      fault_led_o   <= 1'b0;
      chan_sample_o <= {NCHAN*`SLPG_SAMPLE_BITS{1'b0}};
    end
    else
    begin
      run_led_o     <= next_run;
      fault_led_o   <= next_fault;
      chan_sample_o <= chan_sample_i;
    end
  end

endmodule // slpg_top

`default_nettype wire

// >>> verification/slpg_led_monitor.sv
/*
  led state checker for the pattern generator.
  assumes 3 cycles from an input to the leds.
*/
`timescale 1ns/100ps
`default_nettype none
module slpg_led_monitor (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        failed_i,
  input wire logic        watchdog_expired_i,
  input wire logic        self_test_ok_i,
  input wire logic        operational_i,
  input wire logic        auto_addressing_i,
  input wire logic        pre_operational_i,
  input wire logic        over_voltage_i,
  input wire logic [63:0] chan_sample_i,
  input wire logic [63:0] chan_sample_o,
  input wire logic        run_led_o,
  input wire logic        fault_led_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // state terms, fatal ones first
  wire logic wd = !failed_i && watchdog_expired_i;
  wire logic aa = !failed_i && !watchdog_expired_i && auto_addressing_i;
  wire logic h  = !failed_i && !watchdog_expired_i && !auto_addressing_i && !pre_operational_i;
  reset_dark_a: assert property ($rose(rst_n_i) |-> !run_led_o && !fault_led_o)
    else $error("leds lit at reset release");
  fail_dark_a: assert property (failed_i[*4] |-> !run_led_o && !fault_led_o)
    else $error("failed module shows a lit led");
  fatal_first_a: assert property ((failed_i && watchdog_expired_i)[*4] |-> !run_led_o)
    else $error("watchdog beat a failed state");
  wdog_lit_a: assert property (wd[*4] |-> run_led_o && fault_led_o)
    else $error("watchdog expiry not both on");
  addr_dark_a: assert property (aa[*4] |-> !fault_led_o)
    else $error("fault led lit while addressing");
  op_run_a: assert property ((h && operational_i && self_test_ok_i)[*4] |-> run_led_o)
    else $error("healthy module run led dark");
  ov_run_a: assert property ((h && over_voltage_i)[*4] |-> run_led_o)
    else $error("over-voltage run led dark");
  sample_copy_a: assert property ($past(rst_n_i, 4) |-> chan_sample_o == $past(chan_sample_i))
    else $error("sample lanes not passed on");
  cover property (wd[*4]);
  cover property (aa[*4] ##0 $rose(run_led_o));
  cover property ($rose(fault_led_o));
endmodule // slpg_led_monitor
bind slpg_top slpg_led_monitor i_slpg_led_monitor (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .failed_i(failed_i), .watchdog_expired_i(watchdog_expired_i), .self_test_ok_i(self_test_ok_i),
  .operational_i(operational_i), .auto_addressing_i(auto_addressing_i),
  .pre_operational_i(pre_operational_i), .over_voltage_i(over_voltage_i),
  .chan_sample_i(chan_sample_i), .chan_sample_o(chan_sample_o), .run_led_o(run_led_o),
  .fault_led_o(fault_led_o));
`default_nettype wire

// >>> verification/slpg_led_lamp.sv
/*
  lamp model: run lengths of one led in cycles.
  assumes the led is a level, high = lit.
*/
`timescale 1ns/100ps
`default_nettype none
module slpg_led_lamp (
  input  wire logic        clk_i,
  input  wire logic        led_i,
  output var  logic [31:0] on_len_o,
  output var  logic [31:0] off_len_o,
  output var  logic [31:0] rises_o
);
  logic [31:0] cnt     = 32'h0000_0000;
  logic        prev    = 1'b0;
  logic [31:0] on_len  = 32'h0000_0000;
  logic [31:0] off_len = 32'h0000_0000;
  logic [31:0] n_rises = 32'h0000_0000;
  // one driver per output
  assign on_len_o  = on_len;
  assign off_len_o = off_len;
  assign rises_o   = n_rises;
  // finished phase latched at each led edge
  always @(posedge clk_i)
  begin
    prev <= led_i;
    cnt  <= (led_i != prev) ? 32'h0000_0001 : cnt + 32'h0000_0001;
    if (led_i != prev && prev)
      on_len <= cnt;
    if (led_i != prev && !prev)
    begin
      off_len <= cnt;
      n_rises <= n_rises + 32'h0000_0001;
    end
  end
endmodule // slpg_led_lamp
`default_nettype wire

// >>> verification/slpg_top_tb.sv
/*
  bench for slpg_top with a 4-cycle tick.
  assumes lamp models on both leds.
*/
`timescale 1ns/100ps
`default_nettype none
`include "slpg_regs.vh"
module slpg_top_tb;
  // short tick keeps the double-blink scenario well inside the cycle budget
  localparam int TK  = 4;
  localparam int FLK = `SLPG_FLICKER_MS * TK;
  localparam int BLK = `SLPG_BLINK_MS * TK;
  localparam int DBL = (3 * `SLPG_BLINK_MS + `SLPG_DBL_PAUSE_MS) * TK;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic [10:0] st    = 11'h000;
  logic [63:0] smp   = 64'h8001_7fff_1234_fedc;
  wire logic        run;
  wire logic        flt;
  wire logic [63:0] smp_o;
  wire logic [31:0] r_on, r_off, r_n, f_on, f_off, f_n;
  int fail_count = 0;
  int n_checks   = 0;
  int cyc        = 0;
  always #5 clk = ~clk;
  slpg_top #(.TICK_CYCLES(TK)) i_slpg_top (.core_clk_i(clk), .rst_n_i(rst_n), .failed_i(st[0]),
    .watchdog_expired_i(st[1]), .self_test_ok_i(st[2]), .operational_i(st[3]),
    .auto_addressing_i(st[4]), .pre_operational_i(st[5]), .over_voltage_i(st[6]),
    .field_power_local_fault_i(st[7]), .field_power_distributor_fault_i(st[8]),
    .nonfatal_error_i(st[9]), .island_bus_stopped_i(st[10]), .chan_sample_i(smp),
    .chan_sample_o(smp_o), .run_led_o(run), .fault_led_o(flt));
  slpg_led_lamp i_slpg_led_lamp_run (.clk_i(clk), .led_i(run), .on_len_o(r_on), .off_len_o(r_off), .rises_o(r_n));
  slpg_led_lamp i_slpg_led_lamp_flt (.clk_i(clk), .led_i(flt), .on_len_o(f_on), .off_len_o(f_off), .rises_o(f_n));
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, run needs about 27000 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fail_count++;
      complete_run();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task go(input logic [10:0] v);
    @(posedge clk);
    st <= v;
    repeat (8) @(posedge clk);
  endtask
  task steady(input logic r, input logic f);
    repeat (4)
    begin
      repeat (150) @(negedge clk);
      chk("run", r, run);
      chk("fault", f, flt);
    end
  endtask
  // waits at falling edges, lamp values settled
  task rises(input logic s, input int k);
    logic [31:0] n0;
    n0 = s ? f_n : r_n;
    while (((s ? f_n : r_n) - n0) < k) @(negedge clk);
  endtask
  task flick(input logic s, input int w);
    rises(s, 3);
    chk("on", w, s ? f_on : r_on);
    chk("off", w, s ? f_off : r_off);
  endtask
  task t_steady;
    go(11'h7ff);
    steady(1'b0, 1'b0);
    go(11'h7fe);
    steady(1'b1, 1'b1);
    go(11'h00c);
    steady(1'b1, 1'b0);
    // new lane values, so a stuck copy shows up
    @(posedge clk);
    smp <= ~smp;
    repeat (2) @(negedge clk);
    for (int n = 0; n < 4; n++)
      chk("lane", smp[16*n+:16], smp_o[16*n+:16]);
    $display("steady states done");
  endtask
  task t_flicker;
    go(11'h040);
    flick(1'b1, FLK);
    chk("run", 1, run);
    go(11'h480);
    flick(1'b1, FLK);
    go(11'h100);
    flick(1'b1, FLK);
    go(11'h010);
    flick(1'b0, FLK);
    chk("fault", 0, flt);
    $display("flicker done");
  endtask
  task t_blink;
    go(11'h22c);
    flick(1'b0, BLK);
    flick(1'b1, BLK);
    $display("single blink done");
  endtask
  task t_double;
    logic [31:0] a;
    go(11'h600);
    rises(1'b1, 3);
    a = f_off;
    rises(1'b1, 1);
    chk("on", BLK, f_on);
    chk("gap", BLK, a < f_off ? a : f_off);
    chk("period", DBL, a + f_off + 2 * f_on);
    $display("double blink done");
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_steady();
    t_flicker();
    t_blink();
    t_double();
    complete_run();
  end
endmodule // slpg_top_tb
`default_nettype wire
